// ==== inc/arc_fault_pkg.sv ====
// Operation
// - four sensor channels, each taking zero to three point sensors
// - enabled current condition must exceed its limit together with light to trip
// - pressure channels enable into zones like light channels
// - per-channel light detected output follows channel light
// - per-channel pressure detected output follows channel pressure
// - binary input status output follows the energized arc binary input
// - phase and residual start outputs while current exceeds limit
// - phase and residual blocked outputs while blocking input inhibits measurement
// - four zone trip outputs when light, or light and enabled current, hold
// - blocking input turns a satisfied zone trip into zone blocked
// - per-channel sensor fault when detected count differs from configured count
// - unit fault when connected unit count differs from configured count
// - ON and OFF event with timestamp for each of 26 outputs
// - timestamp resolution is one millisecond
// - per-zone trip and blocked counters, software resettable
// - eight setting groups, one common select
// - per-zone enable plus per-channel light enables per zone
// - test pulse option masks external unit pulses off the binary input
// - residual source select none, first or second input, codes 0, 1, 2
`default_nettype none
package arc_fault_pkg;
   localparam int NUM_CH = 4;
   localparam int NUM_ZONE = 4;
   localparam int NUM_GROUP = 8;
   localparam int NUM_OUT = 26;
   localparam int EVT_IDX_W = 5;
   localparam int CNT_W = 16;
   localparam int TS_W = 32;
   localparam int CLK_HZ = 250000000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int TICK_W = 18;
   localparam logic [1:0] MAX_SENSORS = 2'h3;
   localparam logic [1:0] RES_NONE = 2'h0;
   localparam logic [1:0] RES_IN1 = 2'h1;
   localparam logic [1:0] RES_IN2 = 2'h2;
   // event vector bit positions
   localparam int EV_LIGHT = 0;
   localparam int EV_PRESS = 4;
   localparam int EV_BIN = 8;
   localparam int EV_PH_START = 9;
   localparam int EV_RES_START = 10;
   localparam int EV_PH_BLK = 11;
   localparam int EV_RES_BLK = 12;
   localparam int EV_TRIP = 13;
   localparam int EV_ZBLK = 17;
   localparam int EV_SFAULT = 21;
   localparam int EV_IOFAULT = 25;
   typedef enum logic [1:0] {
      SCAN_IDLE = 2'b00,
      SCAN_EMIT = 2'b01
   } scan_e;
endpackage
`default_nettype wire

// ==== rtl/arc_event_scan.sv ====
`default_nettype none
module arc_event_scan
   import arc_fault_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic [NUM_OUT-1:0] outs_i,
   input wire logic [TS_W-1:0] stamp_i,
   input wire logic evt_ready_i,
   output logic evt_valid_o,
   output logic [EVT_IDX_W-1:0] evt_index_o,
   output logic evt_on_o,
   output logic [TS_W-1:0] evt_stamp_o
);
   typedef struct packed {
      logic [NUM_OUT-1:0] logged;
      logic valid;
      logic [EVT_IDX_W-1:0] idx;
      logic on;
      logic [TS_W-1:0] stamp;
   } scan_s;
   scan_s st_ff;
   scan_s nxt_st;
   logic [NUM_OUT-1:0] diff;
   logic found;
   logic [EVT_IDX_W-1:0] pick;
   always_comb begin
      diff = outs_i ^ st_ff.logged;
      found = 1'b0;
      pick = '0;
      for (int i = NUM_OUT - 1; i >= 0; i--) begin
         if (diff[i]) begin
            found = 1'b1;
            pick = EVT_IDX_W'(i);
         end
      end
      nxt_st = st_ff;
      if (st_ff.valid && evt_ready_i) begin
         nxt_st.valid = 1'b0;
      end
      // one event per changed output, lowest index first
      if (!nxt_st.valid && found) begin
         nxt_st.valid = 1'b1;
         nxt_st.idx = pick;
         nxt_st.on = outs_i[pick];
         nxt_st.stamp = stamp_i;
         nxt_st.logged[pick] = outs_i[pick];
      end
   end
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign evt_valid_o = st_ff.valid;
   assign evt_index_o = st_ff.idx;
   assign evt_on_o = st_ff.on;
   assign evt_stamp_o = st_ff.stamp;
endmodule
`default_nettype wire

// ==== rtl/arc_fault_zone_trip.sv ====
`default_nettype none
module arc_fault_zone_trip
   import arc_fault_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_i,
   // sensor side
   input wire logic [NUM_CH-1:0] ch_light_i,
   input wire logic [NUM_CH-1:0] ch_pressure_i,
   input wire logic [NUM_CH*2-1:0] ch_sensor_count_i,
   input wire logic [3:0] io_unit_count_i,
   input wire logic arc_binary_input_i,
   input wire logic test_pulse_i,
   // current measurement side
   input wire logic phase_over_i,
   input wire logic res1_over_i,
   input wire logic res2_over_i,
   input wire logic phase_block_i,
   input wire logic res_block_i,
   input wire logic [NUM_ZONE-1:0] zone_block_i,
   // configuration
   input wire logic [2:0] group_sel_i,
   input wire logic [NUM_GROUP*NUM_ZONE-1:0] cfg_zone_en_i,
   input wire logic [NUM_GROUP*NUM_ZONE-1:0] cfg_zone_ph_en_i,
   input wire logic [NUM_GROUP*NUM_ZONE-1:0] cfg_zone_res_en_i,
   input wire logic [NUM_GROUP*NUM_ZONE*NUM_CH-1:0] cfg_light_en_i,
   input wire logic [NUM_GROUP*NUM_ZONE*NUM_CH-1:0] cfg_press_en_i,
   input wire logic [1:0] cfg_res_sel_i,
   input wire logic [NUM_CH*2-1:0] cfg_sensor_count_i,
   input wire logic [3:0] cfg_io_units_i,
   input wire logic cfg_test_pulse_en_i,
   input wire logic counter_clear_i,
   // status
   output logic [NUM_CH-1:0] light_det_o,
   output logic [NUM_CH-1:0] pressure_det_o,
   output logic arc_binary_input_o,
   output logic phase_current_start_o,
   output logic res_current_start_o,
   output logic phase_current_blocked_o,
   output logic res_current_blocked_o,
   output logic [NUM_ZONE-1:0] zone_trip_o,
   output logic [NUM_ZONE-1:0] zone_blocked_o,
   output logic [NUM_CH-1:0] sensor_fault_o,
   output logic io_unit_fault_o,
   output logic [NUM_ZONE*CNT_W-1:0] trip_count_o,
   output logic [NUM_ZONE*CNT_W-1:0] blocked_count_o,
   // event stream
   input wire logic evt_ready_i,
   output logic evt_valid_o,
   output logic [EVT_IDX_W-1:0] evt_index_o,
   output logic evt_on_o,
   output logic [TS_W-1:0] evt_stamp_o
);
   typedef struct packed {
      logic [NUM_CH-1:0] light;
      logic [NUM_CH-1:0] press;
      logic bin;
      logic ph_start;
      logic res_start;
      logic ph_blk;
      logic res_blk;
      logic [NUM_ZONE-1:0] trip;
      logic [NUM_ZONE-1:0] zblk;
      logic [NUM_CH-1:0] sfault;
      logic iofault;
      logic [NUM_ZONE*CNT_W-1:0] trip_cnt;
      logic [NUM_ZONE*CNT_W-1:0] blk_cnt;
   } zone_s;
   zone_s st_ff;
   zone_s nxt_st;
   logic res_over;
   logic [NUM_ZONE-1:0] zone_cond;
   logic [NUM_OUT-1:0] outs;
   logic [TS_W-1:0] stamp;
   logic [NUM_ZONE-1:0] zen;
   logic [NUM_ZONE-1:0] zph;
   logic [NUM_ZONE-1:0] zres;
   logic [NUM_ZONE*NUM_CH-1:0] zlight;
   logic [NUM_ZONE*NUM_CH-1:0] zpress;
   // active setting group from one select
   assign zen = cfg_zone_en_i[group_sel_i*NUM_ZONE +: NUM_ZONE];
   assign zph = cfg_zone_ph_en_i[group_sel_i*NUM_ZONE +: NUM_ZONE];
   assign zres = cfg_zone_res_en_i[group_sel_i*NUM_ZONE +: NUM_ZONE];
   assign zlight = cfg_light_en_i[group_sel_i*NUM_ZONE*NUM_CH +: NUM_ZONE*NUM_CH];
   assign zpress = cfg_press_en_i[group_sel_i*NUM_ZONE*NUM_CH +: NUM_ZONE*NUM_CH];
   always_comb begin
      case (cfg_res_sel_i)
         RES_IN1: res_over = res1_over_i;
         RES_IN2: res_over = res2_over_i;
         default: res_over = 1'b0;
      endcase
   end
   genvar z;
   generate
      for (z = 0; z < NUM_ZONE; z++) begin : g_zone
         logic arc_seen;
         logic cur_ok;
         // zone and channel enables; pressure routed the same way
         assign arc_seen = |((zlight[z*NUM_CH +: NUM_CH] & ch_light_i)
                           | (zpress[z*NUM_CH +: NUM_CH] & ch_pressure_i));
         // enabled current must also be over limit
         assign cur_ok = (!zph[z] || (phase_over_i && !phase_block_i))
                       && (!zres[z] || (res_over && !res_block_i));
         assign zone_cond[z] = zen[z] && arc_seen && cur_ok;
      end
   endgenerate
   always_comb begin
      nxt_st = st_ff;
      nxt_st.light = ch_light_i;
      nxt_st.press = ch_pressure_i;
      // binary input; test pulses masked when option set
      nxt_st.bin = arc_binary_input_i && !(cfg_test_pulse_en_i && test_pulse_i);
      nxt_st.ph_start = phase_over_i;
      nxt_st.res_start = res_over;
      nxt_st.ph_blk = phase_block_i;
      // codes 0 and 3 select no source, so they may not report a blocked measurement
      nxt_st.res_blk = res_block_i && (cfg_res_sel_i == RES_IN1 || cfg_res_sel_i == RES_IN2);
      nxt_st.trip = zone_cond & ~zone_block_i;
      nxt_st.zblk = zone_cond & zone_block_i;
      // two-bit counts cannot exceed three; fault on any count mismatch
      for (int c = 0; c < NUM_CH; c++) begin
         nxt_st.sfault[c] = ch_sensor_count_i[c*2 +: 2] != cfg_sensor_count_i[c*2 +: 2];
      end
      nxt_st.iofault = io_unit_count_i != cfg_io_units_i;
      // rising-edge counters, clear wins since software asks for zero
      for (int k = 0; k < NUM_ZONE; k++) begin
         if (counter_clear_i) begin
            nxt_st.trip_cnt[k*CNT_W +: CNT_W] = '0;
            nxt_st.blk_cnt[k*CNT_W +: CNT_W] = '0;
         end else begin
            if (nxt_st.trip[k] && !st_ff.trip[k]) begin
               nxt_st.trip_cnt[k*CNT_W +: CNT_W] = st_ff.trip_cnt[k*CNT_W +: CNT_W] + CNT_W'(1);
            end
            if (nxt_st.zblk[k] && !st_ff.zblk[k]) begin
               nxt_st.blk_cnt[k*CNT_W +: CNT_W] = st_ff.blk_cnt[k*CNT_W +: CNT_W] + CNT_W'(1);
            end
         end
      end
   end
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign outs = {st_ff.iofault, st_ff.sfault, st_ff.zblk, st_ff.trip, st_ff.res_blk,
                  st_ff.ph_blk, st_ff.res_start, st_ff.ph_start, st_ff.bin,
                  st_ff.press, st_ff.light};
   arc_ms_tick u_tick (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .tick_o(),
      .stamp_o(stamp)
   );
   arc_event_scan u_scan (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .outs_i(outs),
      .stamp_i(stamp),
      .evt_ready_i(evt_ready_i),
      .evt_valid_o(evt_valid_o),
      .evt_index_o(evt_index_o),
      .evt_on_o(evt_on_o),
      .evt_stamp_o(evt_stamp_o)
   );
   assign light_det_o = st_ff.light;
   assign pressure_det_o = st_ff.press;
   assign arc_binary_input_o = st_ff.bin;
   assign phase_current_start_o = st_ff.ph_start;
   assign res_current_start_o = st_ff.res_start;
   assign phase_current_blocked_o = st_ff.ph_blk;
   assign res_current_blocked_o = st_ff.res_blk;
   assign zone_trip_o = st_ff.trip;
   assign zone_blocked_o = st_ff.zblk;
   assign sensor_fault_o = st_ff.sfault;
   assign io_unit_fault_o = st_ff.iofault;
   assign trip_count_o = st_ff.trip_cnt;
   assign blocked_count_o = st_ff.blk_cnt;
endmodule
`default_nettype wire

// ==== rtl/arc_ms_tick.sv ====
`default_nettype none
module arc_ms_tick
   import arc_fault_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_i,
   output logic tick_o,
   output logic [TS_W-1:0] stamp_o
);
   typedef struct packed {
      logic [TICK_W-1:0] div;
      logic tick;
      logic [TS_W-1:0] stamp;
   } tick_s;
   tick_s st_ff;
   tick_s nxt_st;
   always_comb begin
      nxt_st = st_ff;
      nxt_st.tick = 1'b0;
      if (st_ff.div == TICK_W'(TICK_CYC - 1)) begin
         nxt_st.div = '0;
         nxt_st.tick = 1'b1;
         nxt_st.stamp = st_ff.stamp + TS_W'(1);
      end else begin
         nxt_st.div = st_ff.div + TICK_W'(1);
      end
   end
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign tick_o = st_ff.tick;
   assign stamp_o = st_ff.stamp;
endmodule
`default_nettype wire

// ==== tb/arc_fault_zone_trip_sva.sv ====
`default_nettype none
module arc_fault_zone_trip_sva
   import arc_fault_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic [NUM_CH-1:0] ch_light_i,
   input wire logic [NUM_CH-1:0] ch_pressure_i,
   input wire logic [3:0] io_unit_count_i,
   input wire logic arc_binary_input_i,
   input wire logic test_pulse_i,
   input wire logic phase_over_i,
   input wire logic phase_block_i,
   input wire logic [NUM_ZONE-1:0] zone_block_i,
   input wire logic [3:0] cfg_io_units_i,
   input wire logic cfg_test_pulse_en_i,
   input wire logic evt_ready_i,
   input wire logic [NUM_CH-1:0] light_det_o,
   input wire logic [NUM_CH-1:0] pressure_det_o,
   input wire logic arc_binary_input_o,
   input wire logic phase_current_start_o,
   input wire logic phase_current_blocked_o,
   input wire logic [NUM_ZONE-1:0] zone_trip_o,
   input wire logic [NUM_ZONE-1:0] zone_blocked_o,
   input wire logic io_unit_fault_o,
   input wire logic evt_valid_o,
   input wire logic [EVT_IDX_W-1:0] evt_index_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   // outputs are forced low on the first edge after reset, so skip two edges
   logic [1:0] up_ff;
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) up_ff <= 2'h0;
      else if (up_ff != 2'h2) up_ff <= up_ff + 2'h1;
   end
   a_light_follow: assert property (up_ff == 2'h2 |-> light_det_o == $past(ch_light_i))
      else $error("light detect wrong");
   a_press_follow: assert property (up_ff == 2'h2 |-> pressure_det_o == $past(ch_pressure_i))
      else $error("pressure detect wrong");
   a_bin_masked: assert property (up_ff == 2'h2 |-> arc_binary_input_o ==
      $past(arc_binary_input_i && !(cfg_test_pulse_en_i && test_pulse_i)))
      else $error("binary input status wrong");
   a_phase_start: assert property (up_ff == 2'h2 |-> phase_current_start_o == $past(phase_over_i))
      else $error("phase start wrong");
   a_phase_block: assert property (up_ff == 2'h2 |-> phase_current_blocked_o == $past(phase_block_i))
      else $error("phase blocked wrong");
   a_zone_block: assert property (up_ff == 2'h2 |-> (zone_trip_o & $past(zone_block_i)) == 4'h0
      && (zone_blocked_o & ~$past(zone_block_i)) == 4'h0)
      else $error("zone trip and blocked disagree with block input");
   a_io_fault: assert property (up_ff == 2'h2 |-> io_unit_fault_o ==
      $past(io_unit_count_i != cfg_io_units_i))
      else $error("unit fault wrong");
   a_evt_hold: assert property (evt_valid_o && !evt_ready_i |=> evt_valid_o && $stable(evt_index_o))
      else $error("event dropped before taken");
endmodule
`default_nettype wire

// ==== tb/arc_fault_zone_trip_tb_top.sv ====
`default_nettype none
`default_nettype none
module arc_fault_zone_trip_tb_top
   import arc_fault_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk_i, reset_i, slow, tp, abi, pblk, rblk, tpen, clr, rdy, bo, ps, rs, pb, rb, iof, ev, eon;
   logic [3:0] lreq, preq, cl, cp, zblk, ucnt, ucfg, ld, pd, zt, zb, sf, pt, pz;
   logic [7:0] creq, cc, ccfg;
   logic [2:0] oreq, ov, gsel;
   logic [1:0] rsel;
   logic [31:0] zen, phen, resen, est;
   logic [127:0] len, pren;
   logic [63:0] tc, bc, xtc, xbc;
   logic [4:0] eix;
   int err_total, total_checks, cyc;
   arc_sensor_model pm (.mclk_i(mclk_i), .slow_i(slow), .light_req_i(lreq), .press_req_i(preq),
      .count_req_i(creq), .over_req_i(oreq), .ch_light_o(cl), .ch_pressure_o(cp),
      .ch_sensor_count_o(cc), .over_o(ov));
   arc_fault_zone_trip uut (.mclk_i(mclk_i), .reset_i(reset_i), .ch_light_i(cl),
      .ch_pressure_i(cp), .ch_sensor_count_i(cc), .io_unit_count_i(ucnt),
      .arc_binary_input_i(abi), .test_pulse_i(tp), .phase_over_i(ov[0]), .res1_over_i(ov[1]),
      .res2_over_i(ov[2]), .phase_block_i(pblk), .res_block_i(rblk), .zone_block_i(zblk),
      .group_sel_i(gsel), .cfg_zone_en_i(zen), .cfg_zone_ph_en_i(phen),
      .cfg_zone_res_en_i(resen), .cfg_light_en_i(len), .cfg_press_en_i(pren),
      .cfg_res_sel_i(rsel), .cfg_sensor_count_i(ccfg), .cfg_io_units_i(ucfg),
      .cfg_test_pulse_en_i(tpen), .counter_clear_i(clr), .light_det_o(ld),
      .pressure_det_o(pd), .arc_binary_input_o(bo), .phase_current_start_o(ps),
      .res_current_start_o(rs), .phase_current_blocked_o(pb), .res_current_blocked_o(rb),
      .zone_trip_o(zt), .zone_blocked_o(zb), .sensor_fault_o(sf), .io_unit_fault_o(iof),
      .trip_count_o(tc), .blocked_count_o(bc), .evt_ready_i(rdy), .evt_valid_o(ev),
      .evt_index_o(eix), .evt_on_o(eon), .evt_stamp_o(est));
   always #2 mclk_i = ~mclk_i;
   always @(posedge mclk_i) cyc <= reset_i ? 0 : cyc + 1;
   task automatic end_of_test();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wait_ev(input logic v, input int n);
      for (int w = 0; w < n && ev !== v; w++) begin
         @(posedge mclk_i);
         #1;
      end
   endtask
   function automatic logic rov();
      return rsel == RES_IN1 ? ov[1] : (rsel == RES_IN2 && ov[2]);
   endfunction
   function automatic logic [3:0] cond();
      logic [3:0] r;
      int b;
      for (int z = 0; z < NUM_ZONE; z++) begin
         b = gsel * NUM_ZONE + z;
         r[z] = zen[b] && ((len[b*NUM_CH+:NUM_CH] & cl) | (pren[b*NUM_CH+:NUM_CH] & cp)) != 4'h0
            && (!phen[b] || ov[0] && !pblk) && (!resen[b] || rov() && !rblk);
      end
      return r;
   endfunction
   function automatic logic [3:0] sfx();
      logic [3:0] r;
      for (int i = 0; i < NUM_CH; i++) r[i] = cc[i*2+:2] != ccfg[i*2+:2];
      return r;
   endfunction
   // sensor side goes through the model, the rest lands on the same edge
   task automatic step(input logic s);
      logic [3:0] c;
      logic [351:0] v;
      slow = s;
      {lreq, preq, creq, oreq} = 19'($urandom);
      repeat (s ? 2 : 1) @(posedge mclk_i);
      #1;
      for (int i = 0; i < 11; i++) v = {v[319:0], $urandom};
      {zen, phen, resen, len, pren} = v;
      {abi, tp, tpen, pblk, rblk, zblk, gsel, rsel, rdy, ccfg, ucfg} = 27'($urandom);
      ucnt = ($urandom & 1) ? ucfg : 4'($urandom);
      repeat (2) @(posedge mclk_i);
      #1;
      c = cond();
      for (int z = 0; z < NUM_ZONE; z++) begin
         xtc[z*CNT_W+:CNT_W] += CNT_W'(c[z] & ~zblk[z] & ~pt[z]);
         xbc[z*CNT_W+:CNT_W] += CNT_W'(c[z] & zblk[z] & ~pz[z]);
      end
      pt = c & ~zblk;
      pz = c & zblk;
      chk("light", ld, cl);
      chk("pressure", pd, cp);
      chk("binary", bo, abi & !(tpen & tp));
      chk("starts", {ps, rs}, {ov[0], rov()});
      chk("blocks", {pb, rb}, {pblk, rblk && rsel inside {RES_IN1, RES_IN2}});
      chk("trip", zt, c & ~zblk);
      chk("zone blocked", zb, c & zblk);
      chk("sensor fault", sf, sfx());
      chk("unit fault", iof, ucnt != ucfg);
      chk("trip count", tc, xtc);
      chk("blocked count", bc, xbc);
   endtask
   initial begin
      #100000;
      err_total++;
      end_of_test();
   end
   initial begin
      {mclk_i, reset_i, clr, rdy, slow, lreq, preq, creq, oreq} = {3'h3, 21'h0};
      {abi, tp, tpen, pblk, rblk, zblk, gsel, rsel, ccfg, ucfg, ucnt} = '0;
      {zen, phen, resen, len, pren} = '0;
      {xtc, xbc, pt, pz, err_total, total_checks} = '0;
      void'($urandom(32'h28ac));
      repeat (20) @(posedge mclk_i);
      #1;
      reset_i = 0;
      repeat (2) @(posedge mclk_i);
      #1;
      clr = 0;
      for (int i = 0; i < 300; i++) step(1'($urandom));
      clr = 1;
      repeat (2) @(posedge mclk_i);
      #1;
      chk("cleared trip", tc, 64'h0);
      chk("cleared blocked", bc, 64'h0);
      {clr, xtc, xbc} = '0;
      // held event first, then an event taken at once
      for (int k = 0; k < 2; k++) begin
         rdy = 1;
         wait_ev(0, 500);
         rdy = 1'(k);
         lreq[2] = ~lreq[2];
         wait_ev(1, 10);
         chk("evt valid", ev, 1);
         chk("evt index", eix, EV_LIGHT + 2);
         chk("evt on", eon, lreq[2]);
         chk("evt stamp", est, cyc / TICK_CYC);
      end
      end_of_test();
   end
endmodule
bind arc_fault_zone_trip arc_fault_zone_trip_sva sva_i (.*);
`default_nettype wire

// ==== tb/arc_sensor_model.sv ====
`default_nettype none
module arc_sensor_model
   import arc_fault_pkg::*;
(
   input wire logic mclk_i,
   input wire logic slow_i,
   input wire logic [NUM_CH-1:0] light_req_i,
   input wire logic [NUM_CH-1:0] press_req_i,
   input wire logic [NUM_CH*2-1:0] count_req_i,
   input wire logic [2:0] over_req_i,
   output logic [NUM_CH-1:0] ch_light_o,
   output logic [NUM_CH-1:0] ch_pressure_o,
   output logic [NUM_CH*2-1:0] ch_sensor_count_o,
   output logic [2:0] over_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [NUM_CH*4+2:0] stg;
   initial begin
      stg = '0;
      {ch_light_o, ch_pressure_o, ch_sensor_count_o, over_o} = '0;
   end
   // slow answers a cycle late; all levels move together so no glitch state
   always @(posedge mclk_i) begin
      stg <= {light_req_i, press_req_i, count_req_i, over_req_i};
      {ch_light_o, ch_pressure_o, ch_sensor_count_o, over_o} <= #1 slow_i ? stg :
         {light_req_i, press_req_i, count_req_i, over_req_i};
   end
endmodule
`default_nettype wire
